// ### verilog/fio_consts.svh
`ifndef FIO_CONSTS_SVH
`define FIO_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the plain port)
// ----------------------------------------------------------------
`define FIO_ADDR_W 8
`define FIO_ADDR_CTRL 8'h00
`define FIO_ADDR_IN_LEVEL 8'h04
`define FIO_ADDR_OE_STATE 8'h08
`define FIO_ADDR_DRV_HIGH 8'h0c
`define FIO_ADDR_PIN_BASE 8'h10
`define FIO_ADDR_PIN_STEP 8'h04

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FIO_CTRL_SLOW_BIT 0
`define FIO_CFG_W 15
`define FIO_CFG_MASK_W 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FIO_CTRL_RST 1'b0
`define FIO_PIN_CFG_RST 15'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FIO_SLOW_SLEW_PS 6800
`define FIO_CLK_PERIOD_PS 20000

`endif

// ### verilog/fio_pkg.sv
package fio_pkg;

    typedef enum logic [1:0] {
        FIO_MODE_IN,
        FIO_MODE_OUT,
        FIO_MODE_BIDIR,
        FIO_MODE_PARK
    } fio_mode_t;

    typedef enum logic [1:0] {
        FIO_SLEW_DEFAULT,
        FIO_SLEW_FAST,
        FIO_SLEW_SLOW,
        FIO_SLEW_SLOW_ALT
    } fio_slew_t;

    typedef struct packed {
        logic [5:0] line_mask;
        logic src_adjacent;
        fio_slew_t slew;
        logic in_delay;
        logic open_drain;
        logic oe_inv;
        logic data_inv;
        fio_mode_t mode;
    } fio_pin_cfg_t;

    typedef struct packed {
        logic route_data;
        logic route_oe;
        logic adj_data;
        logic adj_oe;
    } fio_src_t;

    typedef struct packed {
        logic o;
        logic oe;
    } fio_pad_out_t;

endpackage

// ### verilog/fio_pin_drive.sv
`timescale 1ns/1ps
`include "fio_consts.svh"

module fio_pin_drive #(
    parameter int SLEW_CYC = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // configuration
    input wire fio_pkg::fio_pin_cfg_t cfg,
    input wire logic global_slow,
    input wire logic chip_output_disable_pin,
    // sources from routing
    input wire fio_pkg::fio_src_t src,
    // pad
    output fio_pkg::fio_pad_out_t pad
);
    import fio_pkg::*;

    localparam int CW = $clog2(SLEW_CYC + 1);

    logic src_data;
    logic src_oe;
    logic data_v;
    logic oe_v;
    logic next_oe;
    logic next_data;
    logic slow;
    logic [CW-1:0] fall_cnt;
    logic o_q;
    logic oe_q;

    // one driver for the whole pad struct
    assign pad = '{o: o_q, oe: oe_q};

    // ----------------------------------------------------------------
    // source select, inversion, mode
    // ----------------------------------------------------------------
    always_comb begin
        src_data = cfg.src_adjacent ? src.adj_data : src.route_data;
        src_oe = cfg.src_adjacent ? src.adj_oe : src.route_oe;
        data_v = src_data ^ cfg.data_inv;
        oe_v = src_oe ^ cfg.oe_inv;
        unique case (cfg.mode)
            FIO_MODE_IN: next_oe = 1'b0;
            FIO_MODE_OUT: next_oe = cfg.open_drain ? oe_v : 1'b1;
            FIO_MODE_BIDIR: next_oe = oe_v;
            FIO_MODE_PARK: next_oe = 1'b0;
        endcase
        next_data = cfg.open_drain ? 1'b0 : data_v;
        if (chip_output_disable_pin) begin
            next_oe = 1'b0;
        end
        slow = (cfg.slew == FIO_SLEW_SLOW) ||
            (cfg.slew == FIO_SLEW_SLOW_ALT) ||
            ((cfg.slew == FIO_SLEW_DEFAULT) && global_slow);
    end

    // ----------------------------------------------------------------
    // enable flop
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            oe_q <= 1'b0;
        end else if (ce) begin
            oe_q <= next_oe;
        end
    end

    // ----------------------------------------------------------------
    // data flop, falling edge held back when slow
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            o_q <= 1'b0;
            fall_cnt <= '0;
        end else if (ce) begin
            if (cfg.open_drain) begin
                o_q <= 1'b0;
                fall_cnt <= '0;
            end else if (next_data) begin
                o_q <= 1'b1;
                fall_cnt <= '0;
            end else if (!o_q || !slow) begin
                o_q <= 1'b0;
                fall_cnt <= '0;
            end else if (fall_cnt == CW'(SLEW_CYC)) begin
                o_q <= 1'b0;
                fall_cnt <= '0;
            end else begin
                fall_cnt <= fall_cnt + CW'(1);
            end
        end
    end

endmodule

// ### verilog/fio_pin_input.sv
`timescale 1ns/1ps
`include "fio_consts.svh"

module fio_pin_input #(
    parameter int LINES = 6
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // configuration
    input wire logic delay_en,
    input wire logic drive_en,
    input wire logic [LINES-1:0] line_mask,
    // pad and routing
    input wire logic pad_i,
    output logic in_level,
    output logic [LINES-1:0] lines
);
    import fio_pkg::*;

    logic stage1;
    logic stage2;
    logic val;

    assign val = delay_en ? stage2 : stage1;

    // ----------------------------------------------------------------
    // sample, optional delay, fan-out
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            in_level <= 1'b0;
            lines <= '0;
        end else if (ce) begin
            stage1 <= pad_i;
            stage2 <= stage1;
            in_level <= val;
            lines <= drive_en ? (line_mask & {LINES{val}}) : '0;
        end
    end

endmodule

// ### verilog/fio_pin_bank.sv
`timescale 1ns/1ps
`include "fio_consts.svh"


module fio_pin_bank #(
    parameter int NUM_PINS = 10,
    parameter int LINES = 6
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // register port
    input wire logic [`FIO_ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rd_data,
    // chip-wide control
    input wire logic chip_output_disable_pin,
    // sources from the logic array
    input wire fio_pkg::fio_src_t [NUM_PINS-1:0] src,
    // pads
    input wire logic [NUM_PINS-1:0] pad_i,
    output fio_pkg::fio_pad_out_t [NUM_PINS-1:0] pad,
    // routing lines driven by the inputs
    output logic [NUM_PINS*LINES-1:0] route_lines
);
    import fio_pkg::*;

    // ----------------------------------------------------------------
    // derived timing
    // ----------------------------------------------------------------
    localparam int SLEW_RAW = `FIO_SLOW_SLEW_PS / `FIO_CLK_PERIOD_PS;
    localparam int SLEW_CYC = (SLEW_RAW < 1) ? 1 : SLEW_RAW;
    localparam int AW = `FIO_ADDR_W;
    localparam logic [AW-1:0] PIN_END = AW'(`FIO_ADDR_PIN_BASE +
        NUM_PINS * `FIO_ADDR_PIN_STEP);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic global_slow;
    fio_pin_cfg_t pin_cfg [NUM_PINS];
    logic [NUM_PINS-1:0] in_level;
    logic [NUM_PINS-1:0] oe_state;
    logic [NUM_PINS-1:0] drv_high;
    logic [31:0] next_rd_data;
    logic pin_hit;
    logic [AW-1:0] pin_off;
    logic [AW-3:0] pin_idx;

    assign pin_hit = (addr >= `FIO_ADDR_PIN_BASE) && (addr < PIN_END) &&
        (addr[1:0] == 2'b00);
    assign pin_off = addr - `FIO_ADDR_PIN_BASE;
    assign pin_idx = pin_off[AW-1:2];

    // ----------------------------------------------------------------
    // global control register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            global_slow <= `FIO_CTRL_RST;
        end else if (ce && wr && addr == `FIO_ADDR_CTRL) begin
            global_slow <= wr_data[`FIO_CTRL_SLOW_BIT];
        end
    end

    // ----------------------------------------------------------------
    // per-pin configuration, one cell per side slot
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            logic [LINES-1:0] lines_g;
            logic in_used;

            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    pin_cfg[g] <= `FIO_PIN_CFG_RST;
                end else if (ce && wr && pin_hit &&
                        pin_idx == (AW-2)'(g)) begin
                    pin_cfg[g] <= fio_pin_cfg_t'(wr_data[`FIO_CFG_W-1:0]);
                end
            end

            assign in_used = (pin_cfg[g].mode == FIO_MODE_IN) ||
                (pin_cfg[g].mode == FIO_MODE_BIDIR);

            fio_pin_drive #(
                .SLEW_CYC(SLEW_CYC)
            ) u_drive (
                .clock(clock),
                .rst_b(rst_b),
                .ce(ce),
                .cfg(pin_cfg[g]),
                .global_slow(global_slow),
                .chip_output_disable_pin(chip_output_disable_pin),
                .src(src[g]),
                .pad(pad[g])
            );

            fio_pin_input #(
                .LINES(LINES)
            ) u_input (
                .clock(clock),
                .rst_b(rst_b),
                .ce(ce),
                .delay_en(pin_cfg[g].in_delay),
                .drive_en(in_used),
                .line_mask(pin_cfg[g].line_mask[LINES-1:0]),
                .pad_i(pad_i[g]),
                .in_level(in_level[g]),
                .lines(lines_g)
            );

            assign route_lines[g*LINES +: LINES] = lines_g;
            assign oe_state[g] = pad[g].oe;
            assign drv_high[g] = pad[g].oe & pad[g].o;
        end
    endgenerate

    // ----------------------------------------------------------------
    // read mux, data in the cycle after the strobe only
    // ----------------------------------------------------------------
    always_comb begin
        next_rd_data = 32'h0000_0000;
        if (rd) begin
            if (addr == `FIO_ADDR_CTRL) begin
                next_rd_data[`FIO_CTRL_SLOW_BIT] = global_slow;
            end else if (addr == `FIO_ADDR_IN_LEVEL) begin
                next_rd_data[NUM_PINS-1:0] = in_level;
            end else if (addr == `FIO_ADDR_OE_STATE) begin
                next_rd_data[NUM_PINS-1:0] = oe_state;
            end else if (addr == `FIO_ADDR_DRV_HIGH) begin
                next_rd_data[NUM_PINS-1:0] = drv_high;
            end else if (pin_hit) begin
                for (int i = 0; i < NUM_PINS; i++) begin
                    if (pin_idx == (AW-2)'(i)) begin
                        next_rd_data[`FIO_CFG_W-1:0] = pin_cfg[i];
                    end
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 32'h0000_0000;
        end else if (ce) begin
            rd_data <= next_rd_data;
        end
    end

endmodule

// ### dv/fio_pin_bank_monitor.sv
`timescale 1ns/1ps
`include "fio_consts.svh"
module fio_pin_bank_monitor #(
    parameter int NUM_PINS = 10,
    parameter int LINES = 6
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // register port
    input wire logic [`FIO_ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rd_data,
    // pins and routing
    input wire logic chip_output_disable_pin,
    input wire fio_pkg::fio_src_t [NUM_PINS-1:0] src,
    input wire logic [NUM_PINS-1:0] pad_i,
    input wire fio_pkg::fio_pad_out_t [NUM_PINS-1:0] pad,
    input wire logic [NUM_PINS*LINES-1:0] route_lines
);
    import fio_pkg::*;
    fio_src_t src0_q;
    logic src_chg;
    // ----------------------------------------------------------------
    // pin 0 source activity
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            src0_q <= '0;
        end else begin
            src0_q <= src[0];
        end
    end
    assign src_chg = (src[0] != src0_q);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_chip_off;
        chip_output_disable_pin && ce |=> !pad[0].oe && !pad[1].oe;
    endproperty
    a_chip_off: assert property (p_chip_off)
        else $error("enable high under chip disable");
    property p_chip_rise;
        $rose(pad[0].oe) |-> !$past(chip_output_disable_pin);
    endproperty
    a_chip_rise: assert property (p_chip_rise)
        else $error("enable rose with chip disable high");
    property p_indep;
        $changed(pad[1].oe) |-> $past(src[1]) != $past(src[1], 2) ||
            $past(chip_output_disable_pin) !=
            $past(chip_output_disable_pin, 2) || $past(wr, 2);
    endproperty
    a_indep: assert property (p_indep)
        else $error("pin 1 enable moved without cause");
    property p_rise;
        $rose(pad[0].o) |-> $past(src_chg) || $past(wr, 2);
    endproperty
    a_rise: assert property (p_rise)
        else $error("rising output late or causeless");
    property p_fall;
        $fell(pad[0].o) |-> $past(src_chg) || $past(src_chg, 2) ||
            $past(wr, 2) || $past(wr, 3);
    endproperty
    a_fall: assert property (p_fall)
        else $error("falling output beyond slow bound");
    property p_in0;
        (|route_lines[LINES-1:0]) |->
            $past(pad_i[0], 2) || $past(pad_i[0], 3);
    endproperty
    a_in0: assert property (p_in0)
        else $error("pin 0 lines without pad high");
    property p_in1;
        (|route_lines[LINES +: LINES]) |->
            $past(pad_i[1], 2) || $past(pad_i[1], 3);
    endproperty
    a_in1: assert property (p_in1)
        else $error("pin 1 lines without pad high");
    property p_rd_zero;
        !rd && ce |=> rd_data == 32'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("read data outside read slot");
endmodule

bind fio_pin_bank fio_pin_bank_monitor #(
    .NUM_PINS(NUM_PINS), .LINES(LINES)
) mon_u (
    .clock(clock), .rst_b(rst_b), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr(wr), .rd(rd), .rd_data(rd_data),
    .chip_output_disable_pin(chip_output_disable_pin),
    .src(src), .pad_i(pad_i), .pad(pad), .route_lines(route_lines)
);

// ### dv/fio_board.sv
`timescale 1ns/1ps
module fio_board #(
    parameter int NUM_PINS = 2
) (
    // device pads
    input wire fio_pkg::fio_pad_out_t [NUM_PINS-1:0] pad,
    // board drivers
    input wire logic [NUM_PINS-1:0] ext_en,
    input wire logic [NUM_PINS-1:0] ext_val,
    // resolved trace level
    output logic [NUM_PINS-1:0] pad_i
);
    import fio_pkg::*;
    // pull-up on every trace, so a released pin reads high
    always_comb begin
        for (int g = 0; g < NUM_PINS; g++) begin
            if (pad[g].oe) begin
                pad_i[g] = pad[g].o;
            end else if (ext_en[g]) begin
                pad_i[g] = ext_val[g];
            end else begin
                pad_i[g] = 1'b1;
            end
        end
    end
endmodule

// ### dv/fio_pin_bank_bench.sv
`timescale 1ns/1ps
module fio_pin_bank_bench;
    import fio_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ce = 1'b1;
    logic chip_output_disable_pin = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic [31:0] rd_data;
    fio_src_t [1:0] src = '0;
    logic [1:0] ext_en = 2'h0;
    logic [1:0] ext_val = 2'h0;
    logic [1:0] pad_i;
    fio_pad_out_t [1:0] pad;
    logic [11:0] route_lines;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    always #10 clock = ~clock;
    fio_pin_bank #(.NUM_PINS(2), .LINES(6)) dut_u (
        .clock(clock), .rst_b(rst_b), .ce(ce), .addr(addr),
        .wr_data(wr_data), .wr(wr), .rd(rd), .rd_data(rd_data),
        .chip_output_disable_pin(chip_output_disable_pin),
        .src(src), .pad_i(pad_i), .pad(pad), .route_lines(route_lines)
    );
    fio_board #(.NUM_PINS(2)) board_u (
        .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pad_i(pad_i)
    );
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task print_verdict;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task sd(input logic [7:0] v);
        @(posedge clock);
        src <= v;
    endtask
    task wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk("rd_data", e, rd_data);
    endtask
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fail_count++;
            print_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        rreg(8'h10, 32'h0);
        wreg(8'h80, 32'h1ff);
        rreg(8'h80, 32'h0);
        wreg(8'h10, 32'h41);
        wreg(8'h14, 32'h42);
        rreg(8'h14, 32'h42);
        sd(8'h08);
        wt(1);
        chk("pad0", 2'b11, pad[0]);
        chk("pad1", 2'b00, pad[1]);
        sd(8'hc8);
        wt(1);
        chk("pad1", 2'b11, pad[1]);
        // enable low: pads hold while sources move
        @(posedge clock);
        ce <= 1'b0;
        sd(8'h44);
        wt(1);
        chk("freeze", 4'hf, pad);
        sd(8'hc8);
        ce <= 1'b1;
        @(posedge clock);
        chip_output_disable_pin <= 1'b1;
        wt(1);
        chk("oe", 2'b00, {pad[1].oe, pad[0].oe});
        rreg(8'h08, 32'h0);
        @(posedge clock);
        chip_output_disable_pin <= 1'b0;
        wt(1);
        chk("oe", 2'b11, {pad[1].oe, pad[0].oe});
        wreg(8'h14, 32'h4e);
        sd(8'h08);
        wt(1);
        chk("pad1", 2'b11, pad[1]);
        wreg(8'h14, 32'h52);
        sd(8'hc8);
        wt(1);
        chk("pad1", 2'b01, pad[1]);
        rreg(8'h0c, 32'h1);
        sd(8'h88);
        wt(1);
        chk("pad1", 2'b00, pad[1]);
        chk("pad_i1", 1'b1, pad_i[1]);
        // slow via per-pin code, global default, second slow code
        for (int i = 0; i < 3; i++) begin
            wreg(8'h00, i);
            wreg(8'h10, i == 0 ? 32'h81 : (i == 1 ? 32'h01 : 32'hc1));
            sd(8'h00);
            wt(2);
            sd(8'h08);
            wt(1);
            chk("rise", 1'b1, pad[0].o);
            sd(8'h00);
            wt(1);
            chk("hold", 1'b1, pad[0].o);
            wt(1);
            chk("fall", 1'b0, pad[0].o);
        end
        wreg(8'h10, 32'h141);
        sd(8'h02);
        wt(1);
        chk("adj", 1'b1, pad[0].o);
        sd(8'h08);
        wt(1);
        chk("fast", 1'b0, pad[0].o);
        @(posedge clock);
        ext_en <= 2'b11;
        wreg(8'h14, 32'h7e00);
        wreg(8'h10, 32'h7e20);
        wt(3);
        chk("lines", 12'h000, route_lines);
        @(posedge clock);
        ext_val <= 2'b11;
        wt(1);
        chk("lines", 12'h000, route_lines);
        wt(1);
        chk("lines", 12'hfc0, route_lines);
        wt(1);
        chk("lines", 12'hfff, route_lines);
        rreg(8'h04, 32'h3);
        wreg(8'h14, 32'h7e01);
        wt(3);
        chk("lines", 12'h03f, route_lines);
        wreg(8'h10, 32'h7e03);
        wt(2);
        chk("park", 32'h0, {route_lines, pad[0].oe});
        print_verdict;
    end
endmodule
